// *** rtl/agc_pkg.sv ***
// Purpose: Shared constants and types for the receiver gain controller
// Assumes: APB register access, 32-bit data, one word per register
// Notes: Attenuation is counted in steps of STEP_DB decibels

package agc_pkg;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_THRESH = 8'h04;
    localparam logic [7:0] OFF_MANUAL = 8'h08;
    localparam logic [7:0] OFF_DWELL = 8'h0c;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_FLAGS = 8'h14;

    localparam int CTRL_MANUAL_BIT = 0;
    localparam int CTRL_TKO_LSB = 4;
    localparam int MAN_FE_LSB = 0;
    localparam int MAN_BB_LSB = 8;
    localparam int THR_LNA_UL_LSB = 0;
    localparam int THR_LNA_OL_LSB = 4;
    localparam int THR_TIA_UL_LSB = 8;
    localparam int THR_TIA_OL_LSB = 12;
    localparam int ST_REQ_LSB = 0;
    localparam int ST_FE_LSB = 8;
    localparam int ST_BB_LSB = 16;
    localparam int ST_TOT_LSB = 24;

    localparam logic [31:0] CTRL_MASK = 32'h0000_00f1;
    localparam logic [31:0] THRESH_MASK = 32'h0000_ffff;
    localparam logic [31:0] MANUAL_MASK = 32'h0000_0f1f;
    localparam logic [31:0] DWELL_MASK = 32'h0000_ffff;

    localparam logic [31:0] CTRL_RST = 32'h0000_0060;
    localparam logic [31:0] THRESH_RST = 32'h0000_c4c4;
    localparam logic [31:0] MANUAL_RST = 32'h0000_0000;
    localparam logic [31:0] DWELL_RST = 32'h0000_00ff;

    localparam logic [4:0] FE_MAX = 5'h11;
    localparam logic [3:0] BB_MAX = 4'he;
    localparam logic [4:0] REQ_MAX = 5'h1f;
    localparam logic [5:0] STEP_DB = 6'h02;
    localparam int FLAG_W = 4;

    typedef enum logic [1:0] {
        ST_MANUAL = 2'b00,
        ST_DWELL = 2'b01,
        ST_EVAL = 2'b10
    } agc_state_e;
endpackage : agc_pkg

// *** rtl/agc_split_if.sv ***
// Purpose: Carries the requested attenuation and the applied split
// Assumes: One clock domain
// Notes: Controller drives the request, splitter returns the codes

`timescale 1ns/1ps
interface agc_split_if;
    logic [4:0] req;
    logic [3:0] takeover;
    logic manual;
    logic [4:0] man_fe;
    logic [3:0] man_bb;
    logic [4:0] fe;
    logic [3:0] bb;
    logic [4:0] total;

    modport ctrl (output req, takeover, manual, man_fe, man_bb, input fe, bb, total);
    modport split (input req, takeover, manual, man_fe, man_bb, output fe, bb, total);
endinterface : agc_split_if

// *** rtl/agc_sync.sv ***
// Purpose: Two-stage synchroniser for the peak detector flags
// Assumes: Flags are asynchronous comparator levels
// Notes: First stage is read only by the second

`timescale 1ns/1ps
module agc_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [agc_pkg::FLAG_W-1:0] async_in,
    output logic [agc_pkg::FLAG_W-1:0] sync_out
);
    logic [agc_pkg::FLAG_W-1:0] meta_reg;

    for (genvar i = 0; i < agc_pkg::FLAG_W; i++) begin : g_bit
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                meta_reg[i] <= 1'b0;
                sync_out[i] <= 1'b0;
            end else begin
                meta_reg[i] <= async_in[i];
                sync_out[i] <= meta_reg[i];
            end
        end
    end
endmodule : agc_sync

// *** rtl/agc_split.sv ***
// Purpose: Splits requested attenuation between the two attenuators
// Assumes: Takeover level is a baseband step count
// Notes: Codes are registered, one cycle after the request

`timescale 1ns/1ps
module agc_split (
    input wire logic pclk,
    input wire logic presetn,
    agc_split_if.split sp
);
    logic [4:0] fe_next;
    logic [3:0] bb_next;
    logic [3:0] tko;
    logic [5:0] upper;

    always_comb begin
        tko = (sp.takeover > agc_pkg::BB_MAX) ? agc_pkg::BB_MAX : sp.takeover;
        upper = 6'({2'b00, tko}) + 6'(agc_pkg::FE_MAX);
        fe_next = 5'h00;
        bb_next = 4'h0;
        if (sp.manual) begin
            fe_next = (sp.man_fe > agc_pkg::FE_MAX) ? agc_pkg::FE_MAX : sp.man_fe;
            bb_next = (sp.man_bb > agc_pkg::BB_MAX) ? agc_pkg::BB_MAX : sp.man_bb;
        end else if (sp.req <= 5'({1'b0, tko})) begin
            bb_next = sp.req[3:0];
        end else if (6'({1'b0, sp.req}) <= upper) begin
            fe_next = sp.req - 5'({1'b0, tko});
            bb_next = tko;
        end else begin
            fe_next = agc_pkg::FE_MAX;
            bb_next = 4'(sp.req - agc_pkg::FE_MAX);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp.fe <= 5'h00;
            sp.bb <= 4'h0;
            sp.total <= 5'h00;
        end else begin
            sp.fe <= fe_next;
            sp.bb <= bb_next;
            sp.total <= fe_next + 5'({1'b0, bb_next});
        end
    end
endmodule : agc_split

// *** rtl/agc_top.sv ***
// Purpose: Receiver automatic gain control with APB register access
// Assumes: Detector flags are asynchronous and pass a synchroniser
// Notes: Zero wait state APB slave, unmapped addresses raise pslverr
//
// How it works
// - Automatic or manual mode, selected by software
// - Automatic mode steers attenuation without software
// - Inputs are LNA and TIA peak flag pairs
// - Flags outside threshold window request gain change
// - First steps go to baseband attenuator
// - Past takeover, front-end attenuator takes steps
// - Front-end saturated, baseband takes remaining steps
// - Takeover threshold is software writable
// - Front-end code has 18 steps of 2 dB
// - Baseband code has 15 steps of 2 dB
// - Applied total equals front-end plus baseband
// - Applied total attenuation goes to receive chain
//
// The address map and the APB slave port were chosen for this implementation.

`timescale 1ns/1ps
module agc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic lna_underload,
    input wire logic lna_overload,
    input wire logic tia_underload,
    input wire logic tia_overload,
    output logic [3:0] lna_ul_thresh,
    output logic [3:0] lna_ol_thresh,
    output logic [3:0] tia_ul_thresh,
    output logic [3:0] tia_ol_thresh,
    output logic [4:0] frontend_attenuation,
    output logic [3:0] baseband_attenuation,
    output logic [4:0] applied_att_steps,
    output logic [5:0] applied_att_db
);
    logic [31:0] ctrl_reg;
    logic [31:0] thresh_reg;
    logic [31:0] manual_reg;
    logic [31:0] dwell_reg;
    logic [31:0] prdata_reg;
    logic [31:0] rd_next;
    logic [4:0] req_reg;
    logic [4:0] req_next;
    logic [15:0] cnt_reg;
    logic [5:0] db_reg;
    logic [agc_pkg::FLAG_W-1:0] flags;
    logic any_ol;
    logic any_ul;
    logic mapped;
    logic wr_en;
    logic rd_setup;
    logic manual_sel;
    agc_pkg::agc_state_e state_reg;
    agc_pkg::agc_state_e state_next;

    agc_split_if sp ();

    agc_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({tia_overload, tia_underload, lna_overload, lna_underload}),
        .sync_out(flags)
    );

    agc_split u_split (
        .pclk(pclk),
        .presetn(presetn),
        .sp(sp)
    );

    // Byte lane merge for writes
    function automatic logic [31:0] agc_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb, input logic [31:0] mask);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res & mask;
    endfunction : agc_merge

    // APB decode
    always_comb begin
        case (paddr)
            agc_pkg::OFF_CTRL, agc_pkg::OFF_THRESH, agc_pkg::OFF_MANUAL,
            agc_pkg::OFF_DWELL, agc_pkg::OFF_STATUS, agc_pkg::OFF_FLAGS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    assign wr_en = psel && penable && pwrite && mapped;
    assign rd_setup = psel && !penable;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = prdata_reg;

    // Read data is captured in the setup cycle
    always_comb begin
        case (paddr)
            agc_pkg::OFF_CTRL: rd_next = ctrl_reg;
            agc_pkg::OFF_THRESH: rd_next = thresh_reg;
            agc_pkg::OFF_MANUAL: rd_next = manual_reg;
            agc_pkg::OFF_DWELL: rd_next = dwell_reg;
            agc_pkg::OFF_STATUS: begin
                rd_next = 32'h0000_0000;
                rd_next[agc_pkg::ST_REQ_LSB +: 5] = req_reg;
                rd_next[agc_pkg::ST_FE_LSB +: 5] = sp.fe;
                rd_next[agc_pkg::ST_BB_LSB +: 4] = sp.bb;
                rd_next[agc_pkg::ST_TOT_LSB +: 5] = sp.total;
            end
            agc_pkg::OFF_FLAGS: rd_next = {26'h000_0000, state_reg, flags};
            default: rd_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (rd_setup && !pwrite) begin
            prdata_reg <= rd_next;
        end
    end

    // Software registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= agc_pkg::CTRL_RST;
            thresh_reg <= agc_pkg::THRESH_RST;
            manual_reg <= agc_pkg::MANUAL_RST;
            dwell_reg <= agc_pkg::DWELL_RST;
        end else if (wr_en) begin
            case (paddr)
                agc_pkg::OFF_CTRL: ctrl_reg <= agc_merge(ctrl_reg, pwdata, pstrb, agc_pkg::CTRL_MASK);
                agc_pkg::OFF_THRESH: thresh_reg <= agc_merge(thresh_reg, pwdata, pstrb, agc_pkg::THRESH_MASK);
                agc_pkg::OFF_MANUAL: manual_reg <= agc_merge(manual_reg, pwdata, pstrb, agc_pkg::MANUAL_MASK);
                agc_pkg::OFF_DWELL: dwell_reg <= agc_merge(dwell_reg, pwdata, pstrb, agc_pkg::DWELL_MASK);
                default: ;
            endcase
        end
    end

    assign manual_sel = ctrl_reg[agc_pkg::CTRL_MANUAL_BIT];

    // Detector windows
    assign lna_ul_thresh = thresh_reg[agc_pkg::THR_LNA_UL_LSB +: 4];
    assign lna_ol_thresh = thresh_reg[agc_pkg::THR_LNA_OL_LSB +: 4];
    assign tia_ul_thresh = thresh_reg[agc_pkg::THR_TIA_UL_LSB +: 4];
    assign tia_ol_thresh = thresh_reg[agc_pkg::THR_TIA_OL_LSB +: 4];
    assign any_ol = flags[1] || flags[3];
    assign any_ul = flags[0] || flags[2];

    // Mode and dwell sequencing
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            agc_pkg::ST_MANUAL: begin
                if (!manual_sel) begin
                    state_next = agc_pkg::ST_DWELL;
                end
            end
            agc_pkg::ST_DWELL: begin
                if (manual_sel) begin
                    state_next = agc_pkg::ST_MANUAL;
                end else if (cnt_reg == 16'h0000) begin
                    state_next = agc_pkg::ST_EVAL;
                end
            end
            agc_pkg::ST_EVAL: begin
                state_next = manual_sel ? agc_pkg::ST_MANUAL : agc_pkg::ST_DWELL;
            end
            default: state_next = agc_pkg::ST_DWELL;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= agc_pkg::ST_DWELL;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= agc_pkg::DWELL_RST[15:0];
        end else if (state_reg != agc_pkg::ST_DWELL) begin
            cnt_reg <= dwell_reg[15:0];
        end else if (cnt_reg != 16'h0000) begin
            cnt_reg <= cnt_reg - 16'h0001;
        end
    end

    // Requested attenuation
    always_comb begin
        req_next = req_reg;
        if (state_reg == agc_pkg::ST_MANUAL) begin
            req_next = sp.total;
        end else if (state_reg == agc_pkg::ST_EVAL) begin
            if (any_ol && req_reg != agc_pkg::REQ_MAX) begin
                req_next = req_reg + 5'h01;
            end else if (!any_ol && any_ul && req_reg != 5'h00) begin
                req_next = req_reg - 5'h01;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_reg <= 5'h00;
        end else begin
            req_reg <= req_next;
        end
    end

    assign sp.req = req_reg;
    assign sp.takeover = ctrl_reg[agc_pkg::CTRL_TKO_LSB +: 4];
    assign sp.manual = manual_sel;
    assign sp.man_fe = manual_reg[agc_pkg::MAN_FE_LSB +: 5];
    assign sp.man_bb = manual_reg[agc_pkg::MAN_BB_LSB +: 4];

    assign frontend_attenuation = sp.fe;
    assign baseband_attenuation = sp.bb;
    assign applied_att_steps = sp.total;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            db_reg <= 6'h00;
        end else begin
            db_reg <= 6'(6'({1'b0, sp.total}) * agc_pkg::STEP_DB);
        end
    end
    assign applied_att_db = db_reg;

    // Checks
    logic [3:0] tko_chk;
    assign tko_chk = (sp.takeover > agc_pkg::BB_MAX) ? agc_pkg::BB_MAX : sp.takeover;

    total_sum_a: assert property (@(posedge pclk) disable iff (!presetn)
        sp.total == sp.fe + 5'({1'b0, sp.bb}))
        else $error("total differs from the sum of the codes");

    auto_track_a: assert property (@(posedge pclk) disable iff (!presetn)
        !sp.manual && $stable(sp.manual) |-> sp.total == $past(sp.req))
        else $error("applied total does not follow request");

    bb_first_a: assert property (@(posedge pclk) disable iff (!presetn)
        !sp.manual && sp.req <= 5'({1'b0, tko_chk}) && $stable(sp.takeover) |=> sp.fe == 5'h00)
        else $error("front-end attenuated below takeover");

    fe_takes_a: assert property (@(posedge pclk) disable iff (!presetn)
        !sp.manual && $stable(sp.takeover) && sp.req > 5'({1'b0, tko_chk})
        && 6'(sp.req) <= 6'(tko_chk) + 6'(agc_pkg::FE_MAX) |=> sp.bb == $past(tko_chk))
        else $error("baseband not held at takeover");

    fe_sat_a: assert property (@(posedge pclk) disable iff (!presetn)
        !sp.manual && 6'(sp.req) > 6'(tko_chk) + 6'(agc_pkg::FE_MAX)
        |=> sp.fe == agc_pkg::FE_MAX && sp.bb == $past(sp.req) - agc_pkg::FE_MAX)
        else $error("excess not given to baseband");

    code_range_a: assert property (@(posedge pclk) disable iff (!presetn)
        sp.fe <= agc_pkg::FE_MAX && sp.bb <= agc_pkg::BB_MAX)
        else $error("attenuator code out of range");

    step_up_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == agc_pkg::ST_EVAL && any_ol && req_reg != agc_pkg::REQ_MAX
        |=> req_reg == $past(req_reg) + 5'h01)
        else $error("overload did not raise attenuation");

    step_down_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == agc_pkg::ST_EVAL && !any_ol && any_ul && req_reg != 5'h00
        |=> req_reg == $past(req_reg) - 5'h01)
        else $error("underload did not lower attenuation");

    manual_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        sp.manual && sp.man_fe <= agc_pkg::FE_MAX && sp.man_bb <= agc_pkg::BB_MAX
        |=> sp.fe == $past(sp.man_fe) && sp.bb == $past(sp.man_bb))
        else $error("manual codes not applied");

    db_out_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 applied_att_db == 6'(6'($past(applied_att_steps)) * agc_pkg::STEP_DB))
        else $error("reported attenuation in dB is wrong");

    reset_start_a: assert property (@(posedge pclk)
        presetn && !$past(presetn) |-> req_reg == 5'h00 && !manual_sel && sp.total == 5'h00)
        else $error("reset state is not automatic with zero attenuation");

    hold_dwell_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == agc_pkg::ST_DWELL && !manual_sel |=> req_reg == $past(req_reg))
        else $error("request changed during dwell");

    manual_track_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == agc_pkg::ST_MANUAL |=> req_reg == $past(sp.total))
        else $error("request does not track manual total");

    step_size_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg != agc_pkg::ST_MANUAL |=> req_reg == $past(req_reg) || req_reg == $past(req_reg) + 5'h01
        || req_reg == $past(req_reg) - 5'h01)
        else $error("request moved by more than one step");

    no_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == agc_pkg::ST_EVAL && !any_ol |=> req_reg <= $past(req_reg))
        else $error("attenuation rose without overload");

    top_clamp_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == agc_pkg::ST_EVAL && any_ol && req_reg == agc_pkg::REQ_MAX |=> req_reg == agc_pkg::REQ_MAX)
        else $error("request left its upper clamp");

    zero_clamp_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == agc_pkg::ST_EVAL && !any_ol && any_ul && req_reg == 5'h00 |=> req_reg == 5'h00)
        else $error("request left its lower clamp");

    fe_clamp_a: assert property (@(posedge pclk) disable iff (!presetn)
        sp.manual && sp.man_fe > agc_pkg::FE_MAX |=> sp.fe == agc_pkg::FE_MAX)
        else $error("manual front-end code not clamped");

    bb_clamp_a: assert property (@(posedge pclk) disable iff (!presetn)
        sp.manual && sp.man_bb > agc_pkg::BB_MAX |=> sp.bb == agc_pkg::BB_MAX)
        else $error("manual baseband code not clamped");

    fe_max_c: cover property (@(posedge pclk) disable iff (!presetn)
        !sp.manual && sp.fe == agc_pkg::FE_MAX && sp.bb > tko_chk);
    step_up_c: cover property (@(posedge pclk) disable iff (!presetn)
        state_reg == agc_pkg::ST_EVAL && any_ol ##1 req_reg != 5'h00);
    step_down_c: cover property (@(posedge pclk) disable iff (!presetn)
        state_reg == agc_pkg::ST_EVAL && any_ul && !any_ol && req_reg != 5'h00);
    manual_c: cover property (@(posedge pclk) disable iff (!presetn)
        state_reg == agc_pkg::ST_MANUAL ##1 state_reg == agc_pkg::ST_DWELL);
    clamp_c: cover property (@(posedge pclk) disable iff (!presetn)
        state_reg == agc_pkg::ST_EVAL && any_ol && req_reg == agc_pkg::REQ_MAX);
endmodule : agc_top

// *** verif/agc_fe_model.sv ***
// Purpose: Behavioural analog front-end with LNA and TIA peak detectors
// Assumes: Antenna level given in 2 dB steps, thresholds in the same unit
// Notes: Comparator levels, no hysteresis

`timescale 1ns/1ps
module agc_fe_model (
    input wire logic [6:0] sig_lvl,
    input wire logic [4:0] fe,
    input wire logic [3:0] bb,
    input wire logic [3:0] lna_ul,
    input wire logic [3:0] lna_ol,
    input wire logic [3:0] tia_ul,
    input wire logic [3:0] tia_ol,
    output logic lna_underload,
    output logic lna_overload,
    output logic tia_underload,
    output logic tia_overload
);
    int lna_lvl;
    int tia_lvl;

    always_comb begin
        lna_lvl = int'(sig_lvl) - int'(fe);
        tia_lvl = lna_lvl - int'(bb);
        lna_overload = lna_lvl > int'(lna_ol);
        lna_underload = lna_lvl < int'(lna_ul);
        tia_overload = tia_lvl > int'(tia_ol);
        tia_underload = tia_lvl < int'(tia_ul);
    end
endmodule : agc_fe_model

// *** verif/tb.sv ***
// Purpose: Self-checking bench for the gain controller over APB
// Assumes: Zero wait state slave, front-end model closes the loop
// Notes: Step period shortened through the dwell register

`timescale 1ns/1ps
module tb;
    localparam int DWELL = 2;
    localparam int SETTLE = 34 * (DWELL + 2) + 10;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic lna_uf, lna_of, tia_uf, tia_of;
    logic [3:0] lna_ul_thresh, lna_ol_thresh, tia_ul_thresh, tia_ol_thresh;
    logic [4:0] frontend_attenuation;
    logic [3:0] baseband_attenuation;
    logic [4:0] applied_att_steps;
    logic [5:0] applied_att_db;
    logic [6:0] sig_lvl = 7'h00;
    logic [4:0] steps_prev = 5'h00;
    logic [31:0] rd;
    logic er;
    logic [3:0] tk_tab [6] = '{4'h0, 4'h3, 4'h6, 4'ha, 4'he, 4'hf};
    int n_fail = 0;
    int checked = 0;
    int tko = 6;
    bit mon_on = 1'b0;

    agc_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .lna_underload(lna_uf), .lna_overload(lna_of), .tia_underload(tia_uf),
        .tia_overload(tia_of), .lna_ul_thresh(lna_ul_thresh), .lna_ol_thresh(lna_ol_thresh),
        .tia_ul_thresh(tia_ul_thresh), .tia_ol_thresh(tia_ol_thresh),
        .frontend_attenuation(frontend_attenuation), .baseband_attenuation(baseband_attenuation),
        .applied_att_steps(applied_att_steps), .applied_att_db(applied_att_db));

    agc_fe_model afe (.sig_lvl(sig_lvl), .fe(frontend_attenuation), .bb(baseband_attenuation),
        .lna_ul(lna_ul_thresh), .lna_ol(lna_ol_thresh), .tia_ul(tia_ul_thresh), .tia_ol(tia_ol_thresh),
        .lna_underload(lna_uf), .lna_overload(lna_of), .tia_underload(tia_uf), .tia_overload(tia_of));

    always #2 pclk = ~pclk;

    task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    task give_verdict;
        $display("Comparisons %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict

    task xfer(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
        @(posedge pclk);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        pstrb <= s;
        psel <= 1'b1;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    function automatic logic [8:0] split_exp(input int r, input int t);
        int tc;
        tc = t > 14 ? 14 : t;
        if (r <= tc) return {5'h00, 4'(r)};
        if (r <= tc + 17) return {5'(r - tc), 4'(tc)};
        return {5'h11, 4'(r - 17)};
    endfunction : split_exp

    function automatic int settle(input int s, input int t);
        logic [8:0] c;
        for (int r = 0; r < 31; r++) begin
            c = split_exp(r, t);
            if (s - int'(c[8:4]) <= 12 && s - r <= 12) return r;
        end
        return 31;
    endfunction : settle

    task set_ctrl(input logic [31:0] v);
        mon_on = 1'b0;
        xfer(agc_pkg::OFF_CTRL, 1'b1, v, 4'hf);
        repeat (3) @(posedge pclk);
        tko = int'(v[7:4]);
        mon_on = !v[0];
    endtask : set_ctrl

    task run(input logic [6:0] s, input int exp_r);
        sig_lvl <= s;
        repeat (SETTLE) @(posedge pclk);
        chk(applied_att_steps, exp_r, "settled total");
        xfer(agc_pkg::OFF_STATUS, 1'b0, 32'h0, 4'hf);
        chk(rd[4:0], exp_r, "status request");
    endtask : run

    task reset_check;
        xfer(agc_pkg::OFF_CTRL, 1'b0, 32'h0, 4'hf);
        chk(rd, 32'h0000_0060, "ctrl reset");
        xfer(agc_pkg::OFF_THRESH, 1'b0, 32'h0, 4'hf);
        chk(rd, 32'h0000_c4c4, "thresh reset");
        xfer(agc_pkg::OFF_DWELL, 1'b0, 32'h0, 4'hf);
        chk(rd, 32'h0000_00ff, "dwell reset");
        xfer(agc_pkg::OFF_STATUS, 1'b0, 32'h0, 4'hf);
        chk(rd, 32'h0, "status reset");
        chk({frontend_attenuation, baseband_attenuation}, 9'h000, "codes reset");
        $display("TEST reset values done");
    endtask : reset_check

    // Split watched on every edge while mon_on is set (automatic mode), dB output on every edge out of reset
    always @(posedge pclk) begin
        if (presetn && mon_on) begin
            chk({frontend_attenuation, baseband_attenuation}, split_exp(applied_att_steps, tko), "split");
        end
        if (presetn) begin
            chk(applied_att_db, {steps_prev, 1'b0}, "applied dB");
        end
        steps_prev <= applied_att_steps;
    end

    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        give_verdict();
    end

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        reset_check();
        xfer(agc_pkg::OFF_DWELL, 1'b1, DWELL, 4'hf);
        repeat (260) @(posedge pclk);
        for (int i = 0; i < 6; i++) begin
            set_ctrl({24'h0, tk_tab[i], 4'h0});
            run(7'h3c, 31);
            chk(frontend_attenuation, 5'h11, "fe max");
            chk(baseband_attenuation, 4'he, "bb max");
            run(7'h00, 0);
            if (tk_tab[i] <= 4'h6) begin
                run(7'h14, settle(20, tk_tab[i]));
            end
        end
        $display("TEST takeover sweep done");
        xfer(agc_pkg::OFF_THRESH, 1'b1, 32'h0000_a3b2, 4'h1);
        xfer(agc_pkg::OFF_THRESH, 1'b0, 32'h0, 4'hf);
        chk(rd, 32'h0000_c4b2, "thresh lane");
        chk({tia_ol_thresh, tia_ul_thresh, lna_ol_thresh, lna_ul_thresh}, 16'hc4b2, "thresh ports");
        xfer(agc_pkg::OFF_THRESH, 1'b1, 32'h0000_c4c4, 4'hf);
        $display("TEST thresholds done");
        set_ctrl(32'h0000_0061);
        sig_lvl <= 7'h3c;
        xfer(agc_pkg::OFF_MANUAL, 1'b1, 32'h0000_0905, 4'hf);
        repeat (6) @(posedge pclk);
        chk({frontend_attenuation, baseband_attenuation}, {5'h05, 4'h9}, "manual codes");
        chk(applied_att_db, 6'h1c, "manual dB");
        xfer(agc_pkg::OFF_FLAGS, 1'b0, 32'h0, 4'hf);
        chk(rd, 32'h0000_000a, "flags");
        xfer(agc_pkg::OFF_STATUS, 1'b0, 32'h0, 4'hf);
        chk(rd, 32'h0e09_050e, "manual status");
        xfer(agc_pkg::OFF_MANUAL, 1'b1, 32'h0000_0f1f, 4'hf);
        repeat (6) @(posedge pclk);
        chk({frontend_attenuation, baseband_attenuation}, {5'h11, 4'he}, "manual clamp");
        $display("TEST manual mode done");
        set_ctrl(32'h0000_0060);
        run(7'h3c, 31);
        xfer(agc_pkg::OFF_STATUS, 1'b1, 32'hffff_ffff, 4'hf);
        xfer(agc_pkg::OFF_STATUS, 1'b0, 32'h0, 4'hf);
        chk(rd, 32'h1f0e_111f, "status read only");
        xfer(8'h20, 1'b0, 32'h0, 4'hf);
        chk(rd, 32'h0000_0000, "unmapped read");
        chk(er, 1'b1, "unmapped error");
        $display("TEST bus errors done");
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        reset_check();
        give_verdict();
    end
endmodule : tb
